// [design/svd_cfg.svh]
// Offsets, field positions, reset values and timing for the supply voltage detector
`ifndef SVD_CFG_SVH
`define SVD_CFG_SVH

`define SVD_ADDR_W 12
`define SVD_DATA_W 8
`define SVD_CTRL_ADDR 12'hF85
`define SVD_FLAG_ADDR 12'hF86
`define SVD_MASK_ADDR 12'hF87
`define SVD_GIE_ADDR 12'hF88

`define SVD_DIR_BIT 7
`define SVD_BGS_BIT 6
`define SVD_REFS_BIT 5
`define SVD_EN_BIT 4
`define SVD_LVL_HI 3
`define SVD_LVL_LO 0
`define SVD_EVT_BIT 2
`define SVD_GIE_BIT 7

`define SVD_LVL_EXT 4'hF
`define SVD_RST_BYTE 8'h00
`define SVD_CTRL_WMASK 8'h9F

`define SVD_CLK_MHZ 200
`define SVD_STARTUP_NS 20000
`define SVD_STARTUP_CYC ((`SVD_STARTUP_NS * `SVD_CLK_MHZ + 999) / 1000)
`define SVD_SYNC_W 3

`endif

// [design/svd_pkg.sv]
// Types shared by the supply voltage detector modules
`default_nettype none
`include "svd_cfg.svh"

package svd_pkg;
    typedef logic [`SVD_ADDR_W-1:0] svd_addr_t;
    typedef logic [`SVD_DATA_W-1:0] svd_byte_t;
    typedef enum logic [2:0] {
        SVD_OFF = 3'b001,
        SVD_SETTLE = 3'b010,
        SVD_READY = 3'b100
    } svd_state_e;
endpackage

`default_nettype wire

// [design/svd_sync_if.sv]
// Carrier between the detector control and its input synchroniser
`timescale 1ns/1ps
`default_nettype none
`include "svd_cfg.svh"

interface svd_sync_if;
    logic [`SVD_SYNC_W-1:0] raw;
    logic [`SVD_SYNC_W-1:0] clean;
    modport ctrl (output raw, input clean);
    modport sync (input raw, output clean);
endinterface

`default_nettype wire

// [design/svd_sync.sv]
// Three-stage synchroniser; a change is taken once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
`include "svd_cfg.svh"

module svd_sync (
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Signals to clean
    svd_sync_if.sync sif
);
    import svd_pkg::*;

    logic [`SVD_SYNC_W-1:0] meta, stage2, stage3, clean;
    logic [`SVD_SYNC_W-1:0] next_meta, next_stage2, next_stage3, next_clean;

    // First stage feeds only the second stage
    genvar i;
    generate
        for (i = 0; i < `SVD_SYNC_W; i++) begin : g_bit
            always_comb begin
                next_meta[i] = sif.raw[i];
                next_stage2[i] = meta[i];
                next_stage3[i] = stage2[i];
                next_clean[i] = (stage2[i] == stage3[i]) ? stage3[i] : clean[i];
            end
        end
    endgenerate

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            meta <= '0;
            stage2 <= '0;
            stage3 <= '0;
            clean <= '0;
        end else begin
            meta <= next_meta;
            stage2 <= next_stage2;
            stage3 <= next_stage3;
            clean <= next_clean;
        end
    end

    assign sif.clean = clean;
endmodule

`default_nettype wire

// [design/svd_startup.sv]
// Reference start-up timer: reports the reference usable after each enable
`timescale 1ns/1ps
`default_nettype none
`include "svd_cfg.svh"

module svd_startup #(
    parameter int unsigned STARTUP_CYCLES = `SVD_STARTUP_CYC
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Control and status
    input wire logic enable,
    input wire logic bandgap_stable,
    output logic reference_stable
);
    import svd_pkg::*;

    localparam int CW = $clog2(STARTUP_CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(STARTUP_CYCLES - 1);

    svd_state_e state, next_state;
    logic [CW-1:0] cnt, next_cnt;

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        case (state)
            SVD_OFF: begin
                next_cnt = '0;
                if (enable) begin
                    next_state = SVD_SETTLE;
                end
            end
            SVD_SETTLE: begin
                if (!enable) begin
                    next_state = SVD_OFF; // [R15]
                end else if (cnt == LAST) begin
                    // Interval served; still wait for the band-gap to report stable
                    if (bandgap_stable) begin
                        next_state = SVD_READY; // [R5] [R11]
                    end
                end else begin
                    next_cnt = cnt + CW'(1);
                end
            end
            SVD_READY: begin
                if (!enable) begin
                    next_state = SVD_OFF; // [R15]
                end else if (!bandgap_stable) begin
                    next_state = SVD_SETTLE;
                    next_cnt = '0;
                end
            end
            default: begin
                next_state = SVD_OFF;
                next_cnt = '0;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            state <= SVD_OFF;
            cnt <= '0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
        end
    end

    // Gated by the enable so a disable reads back as not stable on the very next cycle
    assign reference_stable = (state == SVD_READY) && enable; // [R3] [R15]
endmodule

`default_nettype wire

// [design/svd_ctrl.sv]
// Supply voltage detector control, status and interrupt logic
//
// How it works
// R1 - Direction bit 1 flags at/above trip point; 0 flags at/below it.
// R2 - Bit 6 is read-only, shows the band-gap references stable.
// R3 - Bit 5 is read-only, shows the detector may now raise its flag.
// R4 - Enable bit 4 powers the detector; clear powers it down.
// R5 - Each enable waits for stabilisation before the event flag may set.
// R6 - A trip-point hit from the enabled comparator sets the event flag.
// R7 - Control bits 3 to 0 pick the trip level for the analog divider.
// R8 - Level code 1111 routes the comparator from the external trip input.
// R9 - Software disables, writes level, sets direction, then enables.
// R10 - Software then clears a stale flag and sets both interrupt enables.
// R11 - The flag stays blocked until the start-up interval has run out.
// R12 - Detection keeps running in sleep; a hit sets the flag and wakes.
// R13 - Reset returns every register to zero, turning the detector off.
// R14 - Comparator and stability inputs are synchronised before use.
// R15 - Clearing the enable drops reference stable; start-up restarts later.
`timescale 1ns/1ps
`default_nettype none
`include "svd_cfg.svh"

module svd_ctrl #(
    parameter int unsigned STARTUP_CYCLES = `SVD_STARTUP_CYC
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Register port
    input wire svd_pkg::svd_addr_t addr,
    input wire svd_pkg::svd_byte_t wdata,
    input wire logic wr,
    input wire logic rd,
    output svd_pkg::svd_byte_t rdata,
    // Analog section, asynchronous to mclk
    input wire logic cmp_internal_above,
    input wire logic cmp_external_above,
    input wire logic bandgap_ok,
    // Analog section controls
    output logic detector_power_en,
    output logic [3:0] trip_level_select,
    output logic external_trip_input_sel,
    // Interrupt and wake
    output logic irq,
    output logic wake_req
);
    import svd_pkg::*;

    // Control register fields
    logic direction_select, next_direction_select;
    logic monitor_enable, next_monitor_enable;
    logic [3:0] trip_level, next_trip_level;

    // Interrupt registers
    logic voltage_event_flag, next_voltage_event_flag;
    logic voltage_event_irq_enable, next_voltage_event_irq_enable;
    logic global_irq_enable, next_global_irq_enable;

    // Read path and outputs
    svd_byte_t next_rdata;
    logic next_irq;
    logic next_wake_req;
    logic next_power_en;
    logic [3:0] next_trip_out;
    logic next_ext_sel;

    // Synchronised analog status
    logic cmp_int_s, cmp_ext_s, bandgap_stable;
    logic reference_stable;
    logic use_external;
    logic level_above;
    logic trip_hit;
    logic event_set;

    // Register selects
    logic sel_ctrl, sel_flag, sel_mask, sel_gie;

    svd_sync_if sif ();

    function automatic logic hit_addr(input svd_addr_t a, input svd_addr_t reg_addr);
        hit_addr = (a == reg_addr);
    endfunction

    // Register selects, decoded once and shared by the write and read paths
    always_comb begin
        sel_ctrl = 1'b0;
        sel_flag = 1'b0;
        sel_mask = 1'b0;
        sel_gie = 1'b0;
        if (hit_addr(addr, `SVD_CTRL_ADDR)) begin
            sel_ctrl = 1'b1;
        end else if (hit_addr(addr, `SVD_FLAG_ADDR)) begin
            sel_flag = 1'b1;
        end else if (hit_addr(addr, `SVD_MASK_ADDR)) begin
            sel_mask = 1'b1;
        end else if (hit_addr(addr, `SVD_GIE_ADDR)) begin
            sel_gie = 1'b1;
        end
        // Any other address selects nothing: writes drop, reads return zero
    end

    // Analog lines cross into mclk before anything looks at them
    assign sif.raw = {bandgap_ok, cmp_external_above, cmp_internal_above}; // [R14]

    svd_sync u_sync (
        .mclk(mclk),
        .nrst(nrst),
        .sif(sif)
    );

    assign cmp_int_s = sif.clean[0];
    assign cmp_ext_s = sif.clean[1];
    assign bandgap_stable = sif.clean[2]; // [R2] [R14]

    svd_startup #(
        .STARTUP_CYCLES(STARTUP_CYCLES)
    ) u_startup (
        .mclk(mclk),
        .nrst(nrst),
        .enable(monitor_enable),
        .bandgap_stable(bandgap_stable),
        .reference_stable(reference_stable)
    );

    // Comparator source and direction of the excursion
    always_comb begin
        use_external = (trip_level == `SVD_LVL_EXT); // [R8]
        level_above = use_external ? cmp_ext_s : cmp_int_s; // [R8]
        // The comparator resolves equality towards the watched direction
        trip_hit = direction_select ? level_above : !level_above; // [R1]
        // Sleep does not gate this path, so a hit still lands while asleep
        event_set = monitor_enable && reference_stable && trip_hit; // [R5] [R6] [R11] [R12]
    end

    // Control register
    always_comb begin
        next_direction_select = direction_select;
        next_monitor_enable = monitor_enable;
        next_trip_level = trip_level;
        if (wr && sel_ctrl) begin
            // Status bits 6 and 5 are read-only and ignore writes
            next_direction_select = wdata[`SVD_DIR_BIT]; // [R1]
            next_monitor_enable = wdata[`SVD_EN_BIT]; // [R4]
            next_trip_level = wdata[`SVD_LVL_HI:`SVD_LVL_LO]; // [R7]
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            direction_select <= 1'b0; // [R13]
            monitor_enable <= 1'b0; // [R13]
            trip_level <= 4'h0; // [R13]
        end else begin
            direction_select <= next_direction_select;
            monitor_enable <= next_monitor_enable;
            trip_level <= next_trip_level;
        end
    end

    // Interrupt status, mask and global enable
    always_comb begin
        next_voltage_event_flag = voltage_event_flag;
        next_voltage_event_irq_enable = voltage_event_irq_enable;
        next_global_irq_enable = global_irq_enable;
        if (wr && sel_flag && wdata[`SVD_EVT_BIT]) begin
            next_voltage_event_flag = 1'b0;
        end
        // A hit in the clearing cycle wins, so no event is lost
        if (event_set) begin
            next_voltage_event_flag = 1'b1; // [R6]
        end
        if (wr && sel_mask) begin
            next_voltage_event_irq_enable = wdata[`SVD_EVT_BIT];
        end
        if (wr && sel_gie) begin
            next_global_irq_enable = wdata[`SVD_GIE_BIT];
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            voltage_event_flag <= 1'b0; // [R13]
            voltage_event_irq_enable <= 1'b0;
            global_irq_enable <= 1'b0;
        end else begin
            voltage_event_flag <= next_voltage_event_flag;
            voltage_event_irq_enable <= next_voltage_event_irq_enable;
            global_irq_enable <= next_global_irq_enable;
        end
    end

    // Read path: data stand only in the cycle after the strobe
    always_comb begin
        next_rdata = `SVD_RST_BYTE;
        if (rd) begin
            if (sel_ctrl) begin
                next_rdata[`SVD_DIR_BIT] = direction_select;
                next_rdata[`SVD_BGS_BIT] = bandgap_stable; // [R2]
                next_rdata[`SVD_REFS_BIT] = reference_stable; // [R3]
                next_rdata[`SVD_EN_BIT] = monitor_enable;
                next_rdata[`SVD_LVL_HI:`SVD_LVL_LO] = trip_level;
            end else if (sel_flag) begin
                next_rdata[`SVD_EVT_BIT] = voltage_event_flag;
            end else if (sel_mask) begin
                next_rdata[`SVD_EVT_BIT] = voltage_event_irq_enable;
            end else if (sel_gie) begin
                next_rdata[`SVD_GIE_BIT] = global_irq_enable;
            end
        end
    end

    // Zero outside the answer cycle keeps a shared read bus quiet
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            rdata <= `SVD_RST_BYTE;
        end else begin
            rdata <= next_rdata;
        end
    end

    // Analog controls follow the control register on the same edge
    always_comb begin
        next_power_en = next_monitor_enable; // [R4]
        next_trip_out = next_trip_level; // [R7]
        next_ext_sel = (next_trip_level == `SVD_LVL_EXT); // [R8]
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            detector_power_en <= 1'b0; // [R13]
            trip_level_select <= 4'h0;
            external_trip_input_sel <= 1'b0;
        end else begin
            detector_power_en <= next_power_en;
            trip_level_select <= next_trip_out;
            external_trip_input_sel <= next_ext_sel;
        end
    end

    // Interrupt outputs from flip-flops, so a decode glitch never reaches the pins
    always_comb begin
        // Wake ignores the global enable; only the interrupt itself needs it
        next_wake_req = next_voltage_event_flag && next_voltage_event_irq_enable; // [R12]
        next_irq = next_wake_req && next_global_irq_enable;
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            wake_req <= 1'b0;
            irq <= 1'b0;
        end else begin
            wake_req <= next_wake_req;
            irq <= next_irq;
        end
    end
endmodule

`default_nettype wire

// [tb/svd_ctrl_props.sv]
// Port checker for the supply voltage detector control
`timescale 1ns/1ps
`default_nettype none
`include "svd_cfg.svh"
module svd_ctrl_chk import svd_pkg::*; #(
    parameter int unsigned STARTUP_CYCLES = `SVD_STARTUP_CYC
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Register port
    input wire svd_pkg::svd_addr_t addr,
    input wire svd_pkg::svd_byte_t wdata,
    input wire logic wr,
    input wire logic rd,
    input wire svd_pkg::svd_byte_t rdata,
    // Analog inputs
    input wire logic cmp_internal_above,
    input wire logic cmp_external_above,
    input wire logic bandgap_ok,
    // Watched outputs
    input wire logic detector_power_en,
    input wire logic [3:0] trip_level_select,
    input wire logic external_trip_input_sel,
    input wire logic irq,
    input wire logic wake_req
);
    logic ctrl_wr;
    logic ctrl_rd;
    logic mapped;
    assign ctrl_wr = wr && addr == `SVD_CTRL_ADDR;
    assign ctrl_rd = rd && addr == `SVD_CTRL_ADDR;
    assign mapped = addr >= `SVD_CTRL_ADDR && addr <= `SVD_GIE_ADDR;
    chk_power_follow: assert property (@(posedge mclk) disable iff (!nrst)
        ctrl_wr |=> detector_power_en == $past(wdata[4])) else $error("power did not follow");
    chk_level_follow: assert property (@(posedge mclk) disable iff (!nrst)
        ctrl_wr |=> trip_level_select == $past(wdata[3:0])) else $error("level did not follow");
    chk_ext_route: assert property (@(posedge mclk) disable iff (!nrst)
        external_trip_input_sel == (trip_level_select == 4'hF)) else $error("bad routing");
    chk_rd_fields: assert property (@(posedge mclk) disable iff (!nrst)
        ctrl_rd |=> rdata[4:0] == {detector_power_en, trip_level_select})
        else $error("control read mismatch");
    chk_refs_off: assert property (@(posedge mclk) disable iff (!nrst)
        ctrl_rd && !detector_power_en |=> !rdata[5]) else $error("stable while off");
    chk_rdata_idle: assert property (@(posedge mclk) disable iff (!nrst)
        !rd |=> rdata == 8'h00) else $error("read data outside its cycle");
    chk_unmapped_rd: assert property (@(posedge mclk) disable iff (!nrst)
        rd && !mapped |=> rdata == 8'h00) else $error("unmapped read not zero");
    chk_irq_wake: assert property (@(posedge mclk) disable iff (!nrst)
        irq |-> wake_req) else $error("irq without wake");
    chk_power_hold: assert property (@(posedge mclk) disable iff (!nrst)
        !ctrl_wr |=> $stable(detector_power_en)) else $error("power moved without a write");
    chk_level_hold: assert property (@(posedge mclk) disable iff (!nrst)
        !ctrl_wr |=> $stable(trip_level_select)) else $error("level moved without a write");
    chk_reset_off: assert property (@(posedge mclk)
        !nrst |=> !detector_power_en && !irq && !wake_req && rdata == 8'h00)
        else $error("reset left outputs active");
endmodule
bind svd_ctrl svd_ctrl_chk #(.STARTUP_CYCLES(STARTUP_CYCLES)) chk_u (
    .mclk(mclk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .cmp_internal_above(cmp_internal_above),
    .cmp_external_above(cmp_external_above), .bandgap_ok(bandgap_ok),
    .detector_power_en(detector_power_en), .trip_level_select(trip_level_select),
    .external_trip_input_sel(external_trip_input_sel), .irq(irq), .wake_req(wake_req)
);
`default_nettype wire

// [tb/tb.sv]
// Self-checking bench for the supply voltage detector control
`timescale 1ns/1ps
`default_nettype none
`include "svd_cfg.svh"
module tb;
    import svd_pkg::*;
    // Short start-up keeps the run brief
    localparam int unsigned SU = 8;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    svd_addr_t addr = '0;
    svd_byte_t wdata = '0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic cmp_int = 1'b1;
    logic cmp_ext = 1'b1;
    logic bg_ok = 1'b0;
    svd_byte_t rdata;
    logic pwr, ext_sel, irq, wake;
    logic [3:0] lvl_out;
    int error_cnt = 0;
    int n_tests = 0;
    int seed = 51764;
    int cyc = 0;
    always #2.5 mclk = ~mclk;
    svd_ctrl #(.STARTUP_CYCLES(SU)) dut_u (
        .mclk(mclk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .cmp_internal_above(cmp_int), .cmp_external_above(cmp_ext),
        .bandgap_ok(bg_ok), .detector_power_en(pwr), .trip_level_select(lvl_out),
        .external_trip_input_sel(ext_sel), .irq(irq), .wake_req(wake)
    );
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    function automatic svd_byte_t ctrl_exp(input svd_byte_t d, input logic bg, input logic rs);
        return (d & `SVD_CTRL_WMASK) | {1'b0, bg, rs, 5'h00};
    endfunction
    task automatic settle(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic reg_wr(input svd_addr_t a, input svd_byte_t d);
        @(posedge mclk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    task automatic reg_rd(input svd_addr_t a, output svd_byte_t v);
        @(posedge mclk);
        rd <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic wait_wake();
        int i;
        for (i = 0; i < 12 && wake !== 1'b1; i++) begin
            @(posedge mclk);
            #1;
        end
    endtask
    // A hit means the comparator output equals the direction bit
    task automatic run_case(input logic [3:0] lvl, input logic dir);
        svd_byte_t v;
        reg_wr(`SVD_CTRL_ADDR, 8'h00);
        // Wipe a flag left by earlier phases so the start-up check sees only this run
        reg_wr(`SVD_FLAG_ADDR, 8'h04);
        reg_wr(`SVD_CTRL_ADDR, {4'h0, lvl});
        reg_wr(`SVD_CTRL_ADDR, {dir, 3'b000, lvl});
        reg_wr(`SVD_CTRL_ADDR, {dir, 3'b001, lvl});
        {cmp_ext, cmp_int} <= {dir, dir};
        reg_rd(`SVD_CTRL_ADDR, v);
        check("refs early", v[5], 1'b0);
        @(posedge mclk);
        {cmp_ext, cmp_int} <= {~dir, ~dir};
        settle(SU + 8);
        reg_rd(`SVD_CTRL_ADDR, v);
        check("refs ready", v[5], 1'b1);
        reg_rd(`SVD_FLAG_ADDR, v);
        check("startup hit", v, 8'h00);
        reg_wr(`SVD_FLAG_ADDR, 8'h04);
        reg_wr(`SVD_MASK_ADDR, 8'h04);
        reg_wr(`SVD_GIE_ADDR, 8'h80);
        @(posedge mclk);
        {cmp_ext, cmp_int} <= (lvl == `SVD_LVL_EXT) ? {dir, ~dir} : {~dir, dir};
        wait_wake();
        check("wake", wake, 1'b1);
        check("irq", irq, 1'b1);
        reg_wr(`SVD_GIE_ADDR, 8'h00);
        #1 check("irq gie off", irq, 1'b0);
        check("wake gie off", wake, 1'b1);
        @(posedge mclk);
        {cmp_ext, cmp_int} <= {~dir, ~dir};
        settle(8);
        reg_wr(`SVD_FLAG_ADDR, 8'h04);
        #1 check("flag clear", wake, 1'b0);
    endtask
    initial begin
        svd_byte_t v;
        svd_byte_t d;
        int k;
        settle(8);
        nrst <= 1'b1;
        for (k = 0; k < 4; k++) begin
            reg_rd(svd_addr_t'(`SVD_CTRL_ADDR + k), v);
            check("reset reg", v, 8'h00);
        end
        for (k = 0; k < 16; k++) begin
            d = {svd_byte_t'($random(seed))} & 8'hF0 | svd_byte_t'(k);
            reg_wr(`SVD_CTRL_ADDR, d);
            #1 check("level", lvl_out, d[3:0]);
            check("ext sel", ext_sel, k == 15);
            check("power", pwr, d[4]);
            reg_rd(`SVD_CTRL_ADDR, v);
            check("ctrl rd", v, ctrl_exp(d, 1'b0, 1'b0));
        end
        for (k = 0; k < 2; k++) begin
            reg_wr(k ? 12'hF89 : 12'hF84, 8'hFF);
            reg_rd(k ? 12'hF89 : 12'hF84, v);
            check("unmapped", v, 8'h00);
        end
        @(posedge mclk);
        bg_ok <= 1'b1;
        settle(8);
        reg_rd(`SVD_CTRL_ADDR, v);
        check("bandgap", v[6], 1'b1);
        run_case(4'($unsigned($random(seed)) % 15), 1'b0);
        run_case(4'hF, 1'b1);
        // Read straight after the disabling write: stable must already read zero
        @(posedge mclk);
        wr <= 1'b1;
        addr <= `SVD_CTRL_ADDR;
        wdata <= 8'hE5;
        @(posedge mclk);
        wr <= 1'b0;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1 v = rdata;
        check("refs off", v, ctrl_exp(8'hE5, 1'b1, 1'b0));
        @(posedge mclk);
        cmp_int <= 1'b1;
        settle(8);
        reg_rd(`SVD_FLAG_ADDR, v);
        check("hit while off", v, 8'h00);
        // Power up with the external level so the reset has something to undo
        reg_wr(`SVD_CTRL_ADDR, 8'h9F);
        @(posedge mclk);
        nrst <= 1'b0;
        settle(2);
        #1 check("rst pwr", pwr, 1'b0);
        check("rst lvl", {ext_sel, lvl_out}, 5'h00);
        @(posedge mclk);
        nrst <= 1'b1;
        reg_rd(`SVD_CTRL_ADDR, v);
        check("rst ctrl", v & 8'h9F, 8'h00);
        close_out();
    end
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            error_cnt++;
            close_out();
        end
    end
endmodule
`default_nettype wire
